// *** pkg/rucc_consts.vh ***
// Overview of operation
// - Two images, exactly one loaded per configuration
// - Image-select pin sampled after power-up
// - Input register overrides pin on reconfiguration
// - CRC error or watchdog loads other image
// - Error cause and failed image readable
// - Second error waits unless auto-restart set
// - Status, configure or user pin low reconfigures
// - Dual image mode enables upgrade feature
// - Shift control high takes serial input
// - Serial output advances while shifting
// - Watchdog restart on falling edge, 250 ns
// - User reconfigure low reconfigures when enabled
// - Upgrade registers run only in user mode
// - Both controls low copy into input register
// - Capture loads shift register from status logic
// - Shift control high ignores capture control
// - Bits 40 and 39 select captured content
// - Bit 13 selects image when bit 12 set
`ifndef RUCC_CONSTS_VH
`define RUCC_CONSTS_VH

// ***************************************************
// Register layout
// ***************************************************
`define RUCC_SR_W 41
`define RUCC_IR_W 39
`define RUCC_SR_CAP_HI 40
`define RUCC_SR_CAP_LO 39
`define RUCC_IR_SEL_BIT 13
`define RUCC_IR_OVR_BIT 12
`define RUCC_IR_RESET 39'h00_0000_0000
`define RUCC_CAP_CURRENT 2'h0
`define RUCC_CAP_PREV0 2'h1
`define RUCC_CAP_PREV1 2'h2
`define RUCC_CAP_INPUT 2'h3

// ***************************************************
// Status codes
// ***************************************************
`define RUCC_MSM_IDLE 4'h0
`define RUCC_MSM_IMG0 4'h2
`define RUCC_MSM_REV1 4'h3
`define RUCC_MSM_IMG1 4'h4
`define RUCC_MSM_REV0 4'h5
`define RUCC_CAUSE_NCONFIG 4'h8
`define RUCC_CAUSE_CRC 4'h4
`define RUCC_CAUSE_NSTATUS 4'h2
`define RUCC_CAUSE_WDTIMER 4'h1

// ***************************************************
// Timing
// ***************************************************
`define RUCC_CLK_NS 5
`define RUCC_WD_PULSE_NS 250
`define RUCC_WD_PULSE_CYC ((`RUCC_WD_PULSE_NS + `RUCC_CLK_NS - 1) / `RUCC_CLK_NS)
`define RUCC_LOAD_TIME_US 10
`define RUCC_LOAD_CYC (`RUCC_LOAD_TIME_US * 1000 / `RUCC_CLK_NS)
`define RUCC_SYNC_W 10

`endif

// *** logic/rucc_sync.v ***
`timescale 1ns/1ps
`default_nettype none
`include "rucc_consts.vh"

// ***************************************************
// Two-flop synchroniser
// ***************************************************
module rucc_sync (
    // Clock and reset
    input wire clock_i,
    input wire nrst_i,
    // Asynchronous inputs
    input wire [`RUCC_SYNC_W-1:0] async_i,
    // Synchronised outputs
    output wire [`RUCC_SYNC_W-1:0] sync_o
);

reg [`RUCC_SYNC_W-1:0] meta_reg;
reg [`RUCC_SYNC_W-1:0] sync_reg;

always @(posedge clock_i) begin
    if (!nrst_i) begin
        meta_reg <= {`RUCC_SYNC_W{1'b1}};
        sync_reg <= {`RUCC_SYNC_W{1'b1}};
    end else begin
        meta_reg <= async_i;
        sync_reg <= meta_reg;
    end
end

assign sync_o = sync_reg;

endmodule
`default_nettype wire

// *** logic/rucc_wdog.v ***
`timescale 1ns/1ps
`default_nettype none

// ***************************************************
// User watchdog timer
// ***************************************************
module rucc_wdog (
    // Clock and reset
    input wire clock_i,
    input wire nrst_i,
    // Control
    input wire run_i,
    input wire restart_i,
    input wire [28:0] limit_i,
    // Status
    output wire timeout_o
);

reg [28:0] count_reg;
reg timeout_reg;

always @(posedge clock_i) begin
    if (!nrst_i) begin
        count_reg <= 29'h0000000;
        timeout_reg <= 1'b0;
    end else begin
        timeout_reg <= 1'b0;
        if (!run_i || restart_i) begin
            count_reg <= 29'h0000000;
        end else if (count_reg >= limit_i) begin
            timeout_reg <= 1'b1;
            count_reg <= 29'h0000000;
        end else begin
            count_reg <= count_reg + 29'h0000001;
        end
    end
end

assign timeout_o = timeout_reg;

endmodule
`default_nettype wire

// *** logic/rucc_top.v ***
`timescale 1ns/1ps
`default_nettype none
`include "rucc_consts.vh"

// ***************************************************
// Remote upgrade configuration control
// ***************************************************
module rucc_top (
    // Clock and reset
    input wire clock_i,
    input wire nrst_i,
    // Static configuration
    input wire dual_image_mode_i,
    input wire auto_restart_i,
    input wire watchdog_enable_i,
    input wire [28:0] watchdog_timeout_i,
    // Device pins and internal error
    input wire image_select_i,
    input wire ext_status_n_i,
    input wire ext_config_n_i,
    input wire crc_error_i,
    // User logic upgrade interface
    input wire upgrade_clock_i,
    input wire upgrade_serial_in_i,
    input wire shift_control_i,
    input wire capture_update_control_i,
    input wire watchdog_restart_n_i,
    input wire user_reconfigure_n_i,
    output wire upgrade_serial_out_o,
    // Configuration status
    output wire load_start_o,
    output wire load_image_o,
    output wire loading_o,
    output wire user_mode_o,
    output wire waiting_o,
    output wire reverted_o,
    output wire [3:0] msm_state_o
);

// ***************************************************
// States
// ***************************************************
localparam [3:0] ST_POR = 4'h1;
localparam [3:0] ST_LOAD = 4'h2;
localparam [3:0] ST_USER = 4'h4;
localparam [3:0] ST_WAIT = 4'h8;
localparam integer LOAD_CYC = `RUCC_LOAD_CYC;
localparam [10:0] LOAD_LAST = LOAD_CYC[10:0] - 11'h001;

function [31:0] rucc_cause;
    input [3:0] bits;
    input [3:0] msm;
    begin
        rucc_cause = {bits, 2'h0, msm, 22'h000000};
    end
endfunction

// ***************************************************
// Input synchronisation
// ***************************************************
wire [`RUCC_SYNC_W-1:0] sync_w;
wire uclk_s;
wire din_s;
wire shift_s;
wire capt_s;
wire wdrst_n_s;
wire urcfg_n_s;
wire status_n_s;
wire config_n_s;
wire pin_img_s;
wire crc_s;

rucc_sync u_sync (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    // CRC flag enters inverted so the flushed chain reads clear
    .async_i({~crc_error_i,
              image_select_i,
              ext_config_n_i,
              ext_status_n_i,
              user_reconfigure_n_i,
              watchdog_restart_n_i,
              capture_update_control_i,
              shift_control_i,
              upgrade_serial_in_i,
              upgrade_clock_i}),
    .sync_o(sync_w)
);

assign uclk_s = sync_w[0];
assign din_s = sync_w[1];
assign shift_s = sync_w[2];
assign capt_s = sync_w[3];
assign wdrst_n_s = sync_w[4];
assign urcfg_n_s = sync_w[5];
assign status_n_s = sync_w[6];
assign config_n_s = sync_w[7];
assign pin_img_s = sync_w[8];
assign crc_s = ~sync_w[9];

// ***************************************************
// Edge detection
// ***************************************************
reg uclk_d_reg;
reg wdrst_n_d_reg;
reg urcfg_n_d_reg;
reg status_n_d_reg;
reg config_n_d_reg;

always @(posedge clock_i) begin
    if (!nrst_i) begin
        uclk_d_reg <= 1'b1;
        wdrst_n_d_reg <= 1'b1;
        urcfg_n_d_reg <= 1'b1;
        status_n_d_reg <= 1'b1;
        config_n_d_reg <= 1'b1;
    end else begin
        uclk_d_reg <= uclk_s;
        wdrst_n_d_reg <= wdrst_n_s;
        urcfg_n_d_reg <= urcfg_n_s;
        status_n_d_reg <= status_n_s;
        config_n_d_reg <= config_n_s;
    end
end

wire feature_en;
wire uclk_rise;
wire wd_restart;
wire status_fall;
wire config_fall;
wire user_fall;
wire reconfig_evt;

assign feature_en = dual_image_mode_i;
assign uclk_rise = uclk_s & ~uclk_d_reg;
assign wd_restart = wdrst_n_d_reg & ~wdrst_n_s;
assign status_fall = status_n_d_reg & ~status_n_s;
assign config_fall = config_n_d_reg & ~config_n_s;
assign user_fall = feature_en & urcfg_n_d_reg & ~urcfg_n_s;
assign reconfig_evt = status_fall | config_fall | user_fall;

// ***************************************************
// Control state
// ***************************************************
reg [3:0] state_reg;
reg [1:0] por_cnt_reg;
reg [10:0] load_cnt_reg;
reg load_image_reg;
reg load_start_reg;
reg reverted_reg;
reg [3:0] msm_reg;
reg [31:0] prev0_reg;
reg [31:0] prev1_reg;
reg [`RUCC_IR_W-1:0] ir_reg;
reg [`RUCC_SR_W-1:0] sr_reg;

wire wd_timeout;

rucc_wdog u_wdog (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .run_i(feature_en & watchdog_enable_i & (state_reg == ST_USER)),
    .restart_i(wd_restart),
    .limit_i(watchdog_timeout_i),
    .timeout_o(wd_timeout)
);

// ***************************************************
// Next load decision
// ***************************************************
reg go;
reg go_img;
reg go_rev;
reg [3:0] go_msm;
reg rec;
reg [31:0] rec_word;
reg to_wait;
reg sel_img;
reg crc_fault;
reg wd_fault;

always @* begin
    go = 1'b0;
    go_img = load_image_reg;
    go_rev = 1'b0;
    rec = 1'b0;
    rec_word = 32'h00000000;
    to_wait = 1'b0;
    crc_fault = (state_reg == ST_LOAD) & crc_s;
    wd_fault = (state_reg == ST_USER) & wd_timeout;
    if (feature_en && ir_reg[`RUCC_IR_OVR_BIT]) begin
        sel_img = ir_reg[`RUCC_IR_SEL_BIT];
    end else begin
        sel_img = pin_img_s;
    end
    case (state_reg)
        ST_POR: begin
            if (por_cnt_reg == 2'h3) begin
                go = 1'b1;
                go_img = pin_img_s;
            end
        end
        ST_LOAD, ST_USER, ST_WAIT: begin
            if (reconfig_evt) begin
                go = 1'b1;
                go_img = sel_img;
                rec = (state_reg != ST_WAIT);
                if (config_fall) begin
                    rec_word = rucc_cause(`RUCC_CAUSE_NCONFIG, msm_reg);
                end else if (status_fall) begin
                    rec_word = rucc_cause(`RUCC_CAUSE_NSTATUS, msm_reg);
                end else begin
                    rec_word = rucc_cause(4'h0, msm_reg);
                end
            end else if (crc_fault || wd_fault) begin
                rec = 1'b1;
                if (crc_fault) begin
                    rec_word = rucc_cause(`RUCC_CAUSE_CRC, msm_reg);
                end else begin
                    rec_word = rucc_cause(`RUCC_CAUSE_WDTIMER, msm_reg);
                end
                if (feature_en && !reverted_reg) begin
                    go = 1'b1;
                    go_img = ~load_image_reg;
                    go_rev = 1'b1;
                end else if (auto_restart_i) begin
                    go = 1'b1;
                    go_img = sel_img;
                end else begin
                    to_wait = 1'b1;
                end
            end
        end
        default: begin
            go = 1'b1;
            go_img = pin_img_s;
        end
    endcase
    if (go_rev) begin
        go_msm = go_img ? `RUCC_MSM_REV1 : `RUCC_MSM_REV0;
    end else begin
        go_msm = go_img ? `RUCC_MSM_IMG1 : `RUCC_MSM_IMG0;
    end
end

// ***************************************************
// Configuration sequencer
// ***************************************************
always @(posedge clock_i) begin
    if (!nrst_i) begin
        state_reg <= ST_POR;
        por_cnt_reg <= 2'h0;
        load_cnt_reg <= 11'h000;
        load_image_reg <= 1'b0;
        load_start_reg <= 1'b0;
        reverted_reg <= 1'b0;
        msm_reg <= `RUCC_MSM_IDLE;
        prev0_reg <= 32'h00000000;
        prev1_reg <= 32'h00000000;
    end else begin
        load_start_reg <= 1'b0;
        if (state_reg == ST_POR) begin
            por_cnt_reg <= por_cnt_reg + 2'h1;
        end
        if (go) begin
            state_reg <= ST_LOAD;
            load_cnt_reg <= 11'h000;
            load_image_reg <= go_img;
            load_start_reg <= 1'b1;
            reverted_reg <= go_rev;
            msm_reg <= go_msm;
        end else if (to_wait) begin
            state_reg <= ST_WAIT;
        end else if (state_reg == ST_LOAD) begin
            if (load_cnt_reg == LOAD_LAST) begin
                state_reg <= ST_USER;
            end else begin
                load_cnt_reg <= load_cnt_reg + 11'h001;
            end
        end
        if (rec) begin
            if (load_image_reg) begin
                prev1_reg <= rec_word;
            end else begin
                prev0_reg <= rec_word;
            end
        end
    end
end

// ***************************************************
// Upgrade shift and input registers
// ***************************************************
wire ru_tick;
wire [`RUCC_IR_W-1:0] cur_state;

assign ru_tick = uclk_rise & feature_en & (state_reg == ST_USER);
assign cur_state = {5'h00, msm_reg, watchdog_enable_i, watchdog_timeout_i};

always @(posedge clock_i) begin
    if (!nrst_i) begin
        sr_reg <= {`RUCC_SR_W{1'b0}};
        ir_reg <= `RUCC_IR_RESET;
    end else if (ru_tick) begin
        if (shift_s) begin
            // Upper select pair is fed from the outgoing bit
            sr_reg <= {sr_reg[39], sr_reg[0], din_s,
                       sr_reg[38:1]};
        end else if (capt_s) begin
            case (sr_reg[`RUCC_SR_CAP_HI:`RUCC_SR_CAP_LO])
                `RUCC_CAP_CURRENT: begin
                    sr_reg[38:0] <= cur_state;
                end
                `RUCC_CAP_PREV0: begin
                    sr_reg[38:0] <= {7'h00, prev0_reg};
                end
                `RUCC_CAP_PREV1: begin
                    sr_reg[38:0] <= {7'h00, prev1_reg};
                end
                default: begin
                    sr_reg[38:0] <= ir_reg;
                end
            endcase
        end else begin
            ir_reg <= sr_reg[38:0];
        end
    end
end

// ***************************************************
// Outputs
// ***************************************************
assign upgrade_serial_out_o = sr_reg[0];
assign load_start_o = load_start_reg;
assign load_image_o = load_image_reg;
assign loading_o = state_reg[1];
assign user_mode_o = state_reg[2];
assign waiting_o = state_reg[3];
assign reverted_o = reverted_reg;
assign msm_state_o = msm_reg;

endmodule
`default_nettype wire

// *** tb/rucc_top_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module rucc_top_sva (
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Watched inputs
    input wire logic dual_image_mode_i,
    input wire logic auto_restart_i,
    input wire logic image_select_i,
    input wire logic ext_config_n_i,
    input wire logic user_reconfigure_n_i,
    input wire logic upgrade_clock_i,
    // Watched outputs
    input wire logic upgrade_serial_out_o,
    input wire logic load_start_o,
    input wire logic load_image_o,
    input wire logic loading_o,
    input wire logic user_mode_o,
    input wire logic waiting_o,
    input wire logic reverted_o,
    input wire logic [3:0] msm_state_o
);
    logic [11:0] load_cnt_reg;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    // Cycles spent loading since the last start
    always @(posedge clock_i) begin
        if (!nrst_i) begin
            load_cnt_reg <= 12'h000;
        end else if (load_start_o) begin
            load_cnt_reg <= 12'h001;
        end else if (loading_o) begin
            load_cnt_reg <= load_cnt_reg + 12'h001;
        end
    end
    a_start_loads: assert property (
        load_start_o |-> loading_o ##1 (loading_o && !load_start_o))
        else $error("load start not followed by loading");
    a_load_length: assert property (
        $rose(user_mode_o) |-> load_cnt_reg == 12'h7d0)
        else $error("user mode after wrong load length");
    a_mode_excl: assert property (
        !(loading_o && (user_mode_o || waiting_o)))
        else $error("loading overlaps another mode");
    a_msm_code: assert property (
        load_start_o |-> msm_state_o == (reverted_o ?
        (load_image_o ? 4'h3 : 4'h5) : (load_image_o ? 4'h4 : 4'h2)))
        else $error("status code does not match load");
    a_power_image: assert property (
        $rose(nrst_i) |-> ##[3:8] load_start_o ##0
        (load_image_o == image_select_i))
        else $error("first load ignores image select");
    a_user_reload: assert property (
        $fell(user_reconfigure_n_i) && (user_mode_o || waiting_o) &&
        dual_image_mode_i
        |-> ##[2:8] load_start_o)
        else $error("user reconfigure ignored");
    a_config_reload: assert property (
        $fell(ext_config_n_i) && (user_mode_o || waiting_o)
        |-> ##[2:8] load_start_o)
        else $error("configure pin ignored");
    a_wait_manual: assert property (
        waiting_o |-> !auto_restart_i)
        else $error("halted although auto restart set");
    a_sout_steady: assert property (
        (user_mode_o && !upgrade_clock_i) [*6] |=>
        $stable(upgrade_serial_out_o))
        else $error("serial out moved without upgrade tick");
endmodule
bind rucc_top rucc_top_sva i_rucc_top_sva (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .dual_image_mode_i(dual_image_mode_i),
    .auto_restart_i(auto_restart_i),
    .image_select_i(image_select_i),
    .ext_config_n_i(ext_config_n_i),
    .user_reconfigure_n_i(user_reconfigure_n_i),
    .upgrade_clock_i(upgrade_clock_i),
    .upgrade_serial_out_o(upgrade_serial_out_o),
    .load_start_o(load_start_o),
    .load_image_o(load_image_o),
    .loading_o(loading_o),
    .user_mode_o(user_mode_o),
    .waiting_o(waiting_o),
    .reverted_o(reverted_o),
    .msm_state_o(msm_state_o)
);
`default_nettype wire

// *** tb/rucc_user_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rucc_user_model (
    // Upgrade link
    input wire logic sout_i,
    output logic uclk_o,
    output logic din_o,
    output logic shift_o,
    output logic capt_o
);
    initial begin
        uclk_o = 1'b0;
        din_o = 1'b0;
        shift_o = 1'b0;
        capt_o = 1'b0;
    end
    // One tick; clock stands low between frames
    task tick(input logic sh, input logic cp, input logic d, output logic q);
        begin
            shift_o = sh;
            capt_o = cp;
            din_o = sh ? d : ~din_o;
            #24;
            q = sout_i;
            uclk_o = 1'b1;
            #24;
            uclk_o = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// *** tb/test_rucc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_rucc_top;
    logic clock_i, nrst_i, dual_image_mode_i, auto_restart_i;
    logic watchdog_enable_i, image_select_i, ext_status_n_i;
    logic ext_config_n_i, crc_error_i, watchdog_restart_n_i;
    logic user_reconfigure_n_i, q;
    logic [28:0] watchdog_timeout_i;
    logic [38:0] got;
    wire upgrade_clock_i, upgrade_serial_in_i, shift_control_i;
    wire capture_update_control_i, upgrade_serial_out_o, load_start_o;
    wire load_image_o, loading_o, user_mode_o, waiting_o, reverted_o;
    wire [3:0] msm_state_o;
    integer n_fail, n_compared;
    rucc_top i_rucc_top (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .dual_image_mode_i(dual_image_mode_i),
        .auto_restart_i(auto_restart_i),
        .watchdog_enable_i(watchdog_enable_i),
        .watchdog_timeout_i(watchdog_timeout_i),
        .image_select_i(image_select_i),
        .ext_status_n_i(ext_status_n_i),
        .ext_config_n_i(ext_config_n_i),
        .crc_error_i(crc_error_i),
        .upgrade_clock_i(upgrade_clock_i),
        .upgrade_serial_in_i(upgrade_serial_in_i),
        .shift_control_i(shift_control_i),
        .capture_update_control_i(capture_update_control_i),
        .watchdog_restart_n_i(watchdog_restart_n_i),
        .user_reconfigure_n_i(user_reconfigure_n_i),
        .upgrade_serial_out_o(upgrade_serial_out_o),
        .load_start_o(load_start_o),
        .load_image_o(load_image_o),
        .loading_o(loading_o),
        .user_mode_o(user_mode_o),
        .waiting_o(waiting_o),
        .reverted_o(reverted_o),
        .msm_state_o(msm_state_o)
    );
    rucc_user_model i_rucc_user_model (
        .sout_i(upgrade_serial_out_o),
        .uclk_o(upgrade_clock_i),
        .din_o(upgrade_serial_in_i),
        .shift_o(shift_control_i),
        .capt_o(capture_update_control_i)
    );
    task check(input logic [38:0] seen, input logic [38:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("FAIL %0t saw %h want %h", $time, seen, exp);
            end
        end
    endtask
    task summarize;
        begin
            $display("compared %0d mismatched %0d", n_compared, n_fail);
            if (n_fail == 0 && n_compared > 0) begin
                $display("Finished cleanly");
            end else begin
                $display("Finished with errors");
            end
            $finish;
        end
    endtask
    // Shift 41 bits so the register ends up holding v
    task xfer(input logic [40:0] v);
        integer i;
        begin
            for (i = 0; i < 41; i = i + 1) begin
                i_rucc_user_model.tick(1'b1, 1'b1,
                    (i < 2) ? v[40 - i] : v[i - 2], q);
                got[i % 39] = (i < 39) ? q : got[i % 39];
            end
        end
    endtask
    task read(input logic [1:0] s);
        begin
            xfer({s, 39'h00_0000_0000});
            i_rucc_user_model.tick(1'b0, 1'b1, 1'b0, q);
            xfer({s, 39'h00_0000_0000});
        end
    endtask
    task wait_hi(input integer w);
        integer k;
        begin
            for (k = 0; k < 20000 && (w ? user_mode_o : load_start_o) !== 1'b1;
                 k = k + 1) begin
                @(negedge clock_i);
            end
        end
    endtask
    task pulse(input integer p);
        begin
            @(negedge clock_i);
            ext_config_n_i = (p != 0);
            user_reconfigure_n_i = (p != 1);
            watchdog_restart_n_i = (p != 2);
            crc_error_i = (p == 3);
            ext_status_n_i = (p != 4);
            repeat ((p == 2) ? 60 : 1) @(negedge clock_i);
            {ext_config_n_i, user_reconfigure_n_i} = 2'h3;
            {ext_status_n_i, watchdog_restart_n_i} = 2'h3;
            crc_error_i = 1'b0;
        end
    endtask
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    initial begin
        #300000;
        n_fail = n_fail + 1;
        $display("FAIL %0t run did not finish", $time);
        summarize;
    end
    initial begin
        n_fail = 0;
        n_compared = 0;
        {nrst_i, crc_error_i, auto_restart_i} = 3'h0;
        {dual_image_mode_i, watchdog_enable_i, image_select_i} = 3'h7;
        {ext_status_n_i, ext_config_n_i} = 2'h3;
        {watchdog_restart_n_i, user_reconfigure_n_i} = 2'h3;
        watchdog_timeout_i = 29'h0000_2000;
        repeat (4) @(negedge clock_i);
        nrst_i = 1'b1;
        wait_hi(0);
        check(load_image_o, 1'b1);
        check(msm_state_o, 4'h4);
        image_select_i = 1'b0;
        wait_hi(1);
        $display("power-up test done");
        pulse(2);
        read(2'h0);
        check(got, {5'h00, 4'h4, 1'b1, 29'h0000_2000});
        $display("current state test done");
        wait_hi(0);
        check(load_image_o, 1'b0);
        check(reverted_o, 1'b1);
        check(msm_state_o, 4'h5);
        wait_hi(1);
        pulse(2);
        read(2'h2);
        check(got, 39'h00_1100_0000);
        $display("watchdog revert test done");
        pulse(2);
        xfer({2'h3, 39'h00_0000_3000});
        i_rucc_user_model.tick(1'b0, 1'b0, 1'b0, q);
        read(2'h3);
        check(got, 39'h00_0000_3000);
        $display("input register test done");
        pulse(0);
        wait_hi(0);
        check(load_image_o, 1'b1);
        check(reverted_o, 1'b0);
        repeat (10) @(negedge clock_i);
        pulse(3);
        wait_hi(0);
        check(load_image_o, 1'b0);
        repeat (10) @(negedge clock_i);
        pulse(3);
        repeat (20) @(negedge clock_i);
        check(waiting_o, 1'b1);
        check(loading_o, 1'b0);
        pulse(1);
        wait_hi(0);
        check(load_image_o, 1'b1);
        wait_hi(1);
        check(user_mode_o, 1'b1);
        $display("second error test done");
        read(2'h1);
        check(got, 39'h00_4140_0000);
        pulse(4);
        wait_hi(0);
        check(load_image_o, 1'b1);
        wait_hi(1);
        read(2'h2);
        check(got, 39'h00_2100_0000);
        $display("status pin test done");
        pulse(0);
        wait_hi(0);
        auto_restart_i = 1'b1;
        repeat (10) @(negedge clock_i);
        pulse(3);
        wait_hi(0);
        check(reverted_o, 1'b1);
        repeat (10) @(negedge clock_i);
        pulse(3);
        wait_hi(0);
        check(load_image_o, 1'b1);
        check(reverted_o, 1'b0);
        check(msm_state_o, 4'h4);
        repeat (5) @(negedge clock_i);
        check(waiting_o, 1'b0);
        $display("auto restart test done");
        summarize;
    end
endmodule
`default_nettype wire
